// ---- eeprom_pkg.sv ----
// Shared constants and types for the serial EEPROM read and poll link
`default_nettype none
package eeprom_pkg;
  // System clock and bus timing
  localparam int CLK_NS = 10;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int QUARTER_NS = SCL_PERIOD_NS / 4;
  // Least time per quarter bit, rounded up to whole cycles
  localparam int QUARTER_CYC = (QUARTER_NS + CLK_NS - 1) / CLK_NS;
  localparam int QCNT_W = 7;
  localparam logic [QCNT_W-1:0] QUARTER_LAST = QCNT_W'(QUARTER_CYC - 1);
  // Internal write cycle length, a plain default
  localparam int WR_TIME_NS = 5000000;
  localparam int WR_CNT_W = 20;
  // Control byte fields
  localparam logic [3:0] CTRL_CODE = 4'ha;
  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ = 1'b1;
  // Bit counter marks: ninth bit is the acknowledge
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_END = 4'h9;
  localparam logic [3:0] BIT_STEP = 4'h1;
  localparam logic [15:0] ADDR_STEP = 16'h0001;
  localparam logic [6:0] PAGE_STEP = 7'h01;
  localparam logic [7:0] COUNT_STEP = 8'h01;
  localparam logic [1:0] QUARTER_STEP = 2'h1;
  localparam logic [1:0] Q_SAMPLE = 2'h2;
  localparam logic [1:0] Q_LAST = 2'h3;
  // Host command kinds
  typedef enum logic [1:0] {OP_POLL = 2'h0, OP_WRITE = 2'h1, OP_CUR_READ = 2'h2, OP_RAND_READ = 2'h3} op_t;
  // Client protocol states
  typedef enum logic [5:0] {D_IDLE = 6'h01, D_CTRL = 6'h02, D_ADRH = 6'h04, D_ADRL = 6'h08, D_WDATA = 6'h10,
    D_RDATA = 6'h20} dev_state_t;
  // Host bus phases
  typedef enum logic [3:0] {H_IDLE = 4'h1, H_START = 4'h2, H_BYTE = 4'h4, H_STOP = 4'h8} host_state_t;
  // Host byte being moved
  typedef enum logic [5:0] {B_CTRLW = 6'h01, B_ADRH = 6'h02, B_ADRL = 6'h04, B_DATA = 6'h08, B_CTRLR = 6'h10,
    B_RDATA = 6'h20} byte_t;
endpackage
`default_nettype wire

// ---- eeprom_link_if.sv ----
// Two-wire bus between host and EEPROM client, open-drain resolved here
`timescale 1ns/100ps
`default_nettype none
interface eeprom_link_if;
  // Host drives clock and data
  logic sclOut;
  logic sclOe;
  logic sdaOutHost;
  logic sdaOeHost;
  // Client drives data only
  logic sdaOutDev;
  logic sdaOeDev;
  // Resolved wire levels, pulled up when nobody pulls low
  logic scl;
  logic sda;
  assign scl = (sclOe && !sclOut) ? 1'b0 : 1'b1;
  assign sda = ((sdaOeHost && !sdaOutHost) || (sdaOeDev && !sdaOutDev)) ? 1'b0 : 1'b1;
  modport host (output sclOut, output sclOe, output sdaOutHost, output sdaOeHost, input scl, input sda);
  modport device (output sdaOutDev, output sdaOeDev, input scl, input sda);
endinterface
`default_nettype wire

// ---- eeprom_client.sv ----
// Serial EEPROM client: addressing, acknowledge polling and reads
// What this block does
// R1: No acknowledge while write cycle runs.
// R2: Write-ending Stop starts internal write cycle.
// R3: Host polls with write control byte, retries.
// R4: Acknowledge polling byte once cycle done.
// R5: Host reads use direction bit one.
// R6: Current, random and sequential reads supported.
// R7: Current read returns byte after last access.
// R8: Acknowledge read control byte, send data byte.
// R9: Host ends read by nack and Stop.
// R10: Address pointer loaded before repeated Start.
// R11: Host resends control byte for reading.
// R12: After random read pointer is next byte.
// R13: Host acknowledge fetches next consecutive byte.
// R14: Host ends sequential read with nack, Stop.
// R15: Pointer increments by one per byte.
// R16: Pointer wraps from top to zero.
// R17: Answer only matching code and select pins.
// R18: Address high byte first, then low.
// R19: Release data line after host nack.
// R20: Busy from Stop for configurable duration.
`timescale 1ns/100ps
`default_nettype none
module eeprom_client #(
  parameter int WriteCycles = eeprom_pkg::WR_TIME_NS / eeprom_pkg::CLK_NS
) (
  // System clock domain
  input wire logic clk,
  input wire logic rstn,
  // Bus-side sampling clock
  input wire logic linkClk,
  // Bus
  eeprom_link_if.device link,
  // Straps and status
  input wire logic [2:0] deviceSelectPins,
  output logic writeBusy
);
  import eeprom_pkg::*;

  localparam logic [WR_CNT_W-1:0] WrLoad = WR_CNT_W'(WriteCycles);

  // Bus-side state, all on linkClk
  typedef struct packed {
    logic sclMeta;
    logic sclS;
    logic sclPrev;
    logic sdaMeta;
    logic sdaS;
    logic sdaPrev;
    logic [2:0] selMeta;
    logic [2:0] sel;
    logic busyMeta;
    logic busy;
    dev_state_t state;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic drive;
    logic [15:0] ptr;
    logic rw;
    logic hostAck;
    logic wrPend;
    logic wrTog;
  } link_state_t;

  // Timer state, all on clk
  typedef struct packed {
    logic togMeta;
    logic togS;
    logic togPrev;
    logic busy;
    logic [WR_CNT_W-1:0] cnt;
  } timer_state_t;

  link_state_t l_q, l_d;
  timer_state_t t_q, t_d;
  logic [7:0] mem [0:65535]; // Array contents, no reset
  logic memWe;
  logic [15:0] memWa;
  logic [7:0] memWd;
  logic sclRise, sclFall, startSeen, stopSeen, load;

  // Bus conditions from synchronised samples only
  assign sclRise = l_q.sclS && !l_q.sclPrev;
  assign sclFall = !l_q.sclS && l_q.sclPrev;
  assign startSeen = l_q.sclS && l_q.sclPrev && l_q.sdaPrev && !l_q.sdaS;
  assign stopSeen = l_q.sclS && l_q.sclPrev && !l_q.sdaPrev && l_q.sdaS;

  // Bus-side next state
  always_comb begin
    l_d = l_q;
    memWe = 1'b0;
    memWa = l_q.ptr;
    memWd = l_q.shift;
    load = 1'b0;
    // Pins and busy level cross through two flops
    l_d.sclMeta = link.scl;
    l_d.sclS = l_q.sclMeta;
    l_d.sclPrev = l_q.sclS;
    l_d.sdaMeta = link.sda;
    l_d.sdaS = l_q.sdaMeta;
    l_d.sdaPrev = l_q.sdaS;
    l_d.selMeta = deviceSelectPins;
    l_d.sel = l_q.selMeta;
    l_d.busyMeta = t_q.busy;
    l_d.busy = l_q.busyMeta;
    if (startSeen) begin
      // Start or repeated Start cancels any pending write cycle; bytes already stored stay
      l_d.state = D_CTRL;
      l_d.bitCnt = '0;
      l_d.drive = 1'b0;
      l_d.wrPend = 1'b0; // R10
    end else if (stopSeen) begin
      // Stop always releases the data line
      l_d.state = D_IDLE;
      l_d.drive = 1'b0; // R9
      if (l_q.wrPend) begin
        l_d.wrTog = !l_q.wrTog; // R2
        l_d.wrPend = 1'b0;
      end
    end else if (sclRise && l_q.state != D_IDLE) begin
      if (l_q.bitCnt < BIT_ACK) begin
        // Data bits; a sent byte only counts here
        if (l_q.state != D_RDATA) begin
          l_d.shift = {l_q.shift[6:0], l_q.sdaS};
        end
        l_d.bitCnt = l_q.bitCnt + BIT_STEP;
      end else begin
        // Ninth clock: note the host answer
        l_d.hostAck = !l_q.sdaS;
        l_d.bitCnt = BIT_END;
      end
    end else if (sclFall) begin
      unique case (l_q.state)
        D_IDLE: begin
          // Not addressed, stay off the bus
          l_d.drive = 1'b0;
        end
        D_CTRL: begin
          if (l_q.bitCnt == BIT_ACK) begin
            // Code and select must match, and no write may be running
            if (l_q.shift[7:4] == CTRL_CODE && l_q.shift[3:1] == l_q.sel && !l_q.busy) begin // R17
              l_d.drive = 1'b1; // R4 R8
              l_d.rw = l_q.shift[0];
            end else begin
              l_d.state = D_IDLE; // R1 R20
            end
          end else if (l_q.bitCnt == BIT_END) begin
            l_d.bitCnt = '0;
            l_d.drive = 1'b0;
            if (l_q.rw == RW_READ) begin
              l_d.state = D_RDATA; // R6 R7
              load = 1'b1;
            end else begin
              l_d.state = D_ADRH;
            end
          end
        end
        D_ADRH, D_ADRL, D_WDATA: begin
          if (l_q.bitCnt == BIT_ACK) begin
            l_d.drive = 1'b1;
            if (l_q.state == D_ADRH) begin
              l_d.ptr[15:8] = l_q.shift; // R18
            end else if (l_q.state == D_ADRL) begin
              l_d.ptr[7:0] = l_q.shift; // R10
            end else begin
              // Byte stored at once; pointer steps inside its page
              memWe = 1'b1;
              l_d.ptr[6:0] = l_q.ptr[6:0] + PAGE_STEP;
              l_d.wrPend = 1'b1;
            end
          end else if (l_q.bitCnt == BIT_END) begin
            l_d.bitCnt = '0;
            l_d.drive = 1'b0;
            if (l_q.state == D_ADRH) begin
              l_d.state = D_ADRL;
            end else begin
              l_d.state = D_WDATA;
            end
          end
        end
        D_RDATA: begin
          if (l_q.bitCnt == BIT_ACK) begin
            // Let go for the host answer
            l_d.drive = 1'b0;
          end else if (l_q.bitCnt == BIT_END) begin
            if (l_q.hostAck) begin
              load = 1'b1; // R13
            end else begin
              l_d.state = D_IDLE; // R19
              l_d.drive = 1'b0;
            end
          end else if (l_q.bitCnt != '0) begin
            // Next bit out, most significant first
            l_d.shift = {l_q.shift[6:0], 1'b0};
            l_d.drive = !l_q.shift[6];
          end
        end
      endcase
      if (load) begin
        // Fetch and step; the pointer wraps by its own width
        l_d.shift = mem[l_q.ptr];
        l_d.drive = !mem[l_q.ptr][7];
        l_d.ptr = l_q.ptr + ADDR_STEP; // R12 R15 R16
        l_d.bitCnt = '0;
      end
    end
  end

  // Bus-side registers
  always_ff @(posedge linkClk or negedge rstn) begin
    if (!rstn) begin
      l_q <= '{state: D_IDLE, sclMeta: 1'b1, sclS: 1'b1, sclPrev: 1'b1, sdaMeta: 1'b1, sdaS: 1'b1,
        sdaPrev: 1'b1, default: '0};
    end else begin
      l_q <= l_d;
    end
  end

  // Array write port
  always_ff @(posedge linkClk) begin
    if (memWe) begin
      mem[memWa] <= memWd;
    end
  end

  // Write cycle timer; the Stop arrives as a toggle
  always_comb begin
    t_d = t_q;
    t_d.togMeta = l_q.wrTog;
    t_d.togS = t_q.togMeta;
    t_d.togPrev = t_q.togS;
    if (t_q.togS != t_q.togPrev) begin
      t_d.busy = 1'b1; // R2 R20
      t_d.cnt = WrLoad;
    end else if (t_q.busy) begin
      if (t_q.cnt == '0) begin
        t_d.busy = 1'b0; // R4
      end else begin
        t_d.cnt = t_q.cnt - WR_CNT_W'(1);
      end
    end
  end

  // Timer registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      t_q <= '0;
    end else begin
      t_q <= t_d;
    end
  end

  // Open-drain data: only ever pulls low
  assign link.sdaOutDev = 1'b0;
  assign link.sdaOeDev = l_q.drive;
  assign writeBusy = t_q.busy;
endmodule
`default_nettype wire

// ---- eeprom_host.sv ----
// Two-wire bus host issuing polls, writes and reads to the EEPROM client
`timescale 1ns/100ps
`default_nettype none
module eeprom_host (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Bus
  eeprom_link_if.host link,
  // Command
  input wire logic cmdValid,
  output logic cmdReady,
  input wire eeprom_pkg::op_t cmdOp,
  input wire logic [2:0] cmdSelect,
  input wire logic [15:0] cmdAddr,
  input wire logic [7:0] cmdData,
  input wire logic [7:0] cmdCount,
  // Answers
  output logic rdValid,
  output logic [7:0] rdData,
  output logic done,
  output logic nacked
);
  import eeprom_pkg::*;

  // All host state
  typedef struct packed {
    host_state_t state;
    byte_t kind;
    op_t op;
    logic [2:0] sel;
    logic [15:0] addr;
    logic [7:0] data;
    logic [7:0] left;
    logic [QCNT_W-1:0] qCnt;
    logic [1:0] quarter;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic sclHigh;
    logic sdaLow;
    logic sdaMeta;
    logic sdaS;
    logic gotAck;
    logic rdValid;
    logic [7:0] rdData;
    logic done;
    logic nacked;
  } host_reg_t;

  host_reg_t h_q, h_d;
  logic tick, bitLow;

  // Quarter-bit divider ends here
  assign tick = h_q.state != H_IDLE && h_q.qCnt == QUARTER_LAST;

  // Next state
  always_comb begin
    h_d = h_q;
    bitLow = 1'b0;
    h_d.rdValid = 1'b0;
    h_d.done = 1'b0;
    h_d.sdaMeta = link.sda;
    h_d.sdaS = h_q.sdaMeta;
    if (h_q.state == H_IDLE) begin
      if (cmdValid) begin
        // Current read starts straight with a read control byte
        h_d.state = H_START;
        h_d.op = cmdOp;
        h_d.sel = cmdSelect;
        h_d.addr = cmdAddr;
        h_d.data = cmdData;
        h_d.left = (cmdCount == '0) ? COUNT_STEP : cmdCount;
        h_d.nacked = 1'b0;
        h_d.kind = (cmdOp == OP_CUR_READ) ? B_CTRLR : B_CTRLW; // R5
        h_d.qCnt = '0;
        h_d.quarter = '0;
      end
    end else if (!tick) begin
      h_d.qCnt = h_q.qCnt + QCNT_W'(1);
    end else begin
      h_d.qCnt = '0;
      h_d.quarter = h_q.quarter + QUARTER_STEP;
      // Sample the line in the middle of the high time
      if (h_q.state == H_BYTE && h_q.quarter == Q_SAMPLE) begin
        if (h_q.bitCnt == BIT_ACK) begin
          h_d.gotAck = !h_q.sdaS;
        end else if (h_q.kind == B_RDATA) begin
          h_d.shift = {h_q.shift[6:0], h_q.sdaS};
        end
      end
      if (h_q.quarter == Q_LAST) begin
        unique case (h_q.state)
          H_IDLE: begin
            h_d.state = H_IDLE;
          end
          H_START: begin
            h_d.state = H_BYTE;
            h_d.bitCnt = '0;
            h_d.shift = {CTRL_CODE, h_q.sel, (h_q.kind == B_CTRLR) ? RW_READ : RW_WRITE}; // R11
          end
          H_STOP: begin
            h_d.state = H_IDLE;
            h_d.done = 1'b1;
          end
          H_BYTE: begin
            if (h_q.bitCnt != BIT_ACK) begin
              h_d.bitCnt = h_q.bitCnt + BIT_STEP;
              if (h_q.kind != B_RDATA) begin
                h_d.shift = {h_q.shift[6:0], 1'b0};
              end
            end else begin
              h_d.bitCnt = '0;
              unique case (h_q.kind)
                B_CTRLW: begin
                  if (h_q.op == OP_POLL) begin
                    // Retry Start and control byte until answered
                    h_d.state = h_q.gotAck ? H_STOP : H_START; // R3 R4
                  end else if (h_q.gotAck) begin
                    h_d.kind = B_ADRH;
                    h_d.shift = h_q.addr[15:8]; // R18
                  end else begin
                    h_d.state = H_STOP;
                    h_d.nacked = 1'b1;
                  end
                end
                B_ADRH: begin
                  h_d.kind = B_ADRL;
                  h_d.shift = h_q.addr[7:0];
                end
                B_ADRL: begin
                  if (h_q.op == OP_WRITE) begin
                    h_d.kind = B_DATA;
                    h_d.shift = h_q.data;
                  end else begin
                    h_d.state = H_START; // R10
                    h_d.kind = B_CTRLR;
                  end
                end
                B_DATA: begin
                  h_d.state = H_STOP;
                end
                B_CTRLR: begin
                  if (h_q.gotAck) begin
                    h_d.kind = B_RDATA;
                  end else begin
                    h_d.state = H_STOP;
                    h_d.nacked = 1'b1;
                  end
                end
                B_RDATA: begin
                  h_d.rdValid = 1'b1;
                  h_d.rdData = h_q.shift;
                  h_d.left = h_q.left - COUNT_STEP;
                  if (h_q.left == COUNT_STEP) begin
                    h_d.state = H_STOP; // R9 R14
                  end
                end
              endcase
            end
          end
        endcase
      end
    end
    // Bit to pull low: data bits out, or our acknowledge while reading
    if (h_d.bitCnt == BIT_ACK) begin
      bitLow = h_d.kind == B_RDATA && h_d.left != COUNT_STEP; // R14
    end else begin
      bitLow = h_d.kind != B_RDATA && !h_d.shift[7];
    end
    // Pin levels per phase and quarter, registered
    unique case (h_d.state)
      H_IDLE: begin
        h_d.sclHigh = 1'b1;
        h_d.sdaLow = 1'b0;
      end
      H_START: begin
        h_d.sclHigh = h_d.quarter == QUARTER_STEP || h_d.quarter == Q_SAMPLE;
        h_d.sdaLow = h_d.quarter[1];
      end
      H_STOP: begin
        h_d.sclHigh = h_d.quarter != '0;
        h_d.sdaLow = !h_d.quarter[1];
      end
      H_BYTE: begin
        h_d.sclHigh = h_d.quarter[1];
        h_d.sdaLow = bitLow;
      end
    endcase
  end

  // Host registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      h_q <= '{state: H_IDLE, kind: B_CTRLW, op: OP_POLL, sclHigh: 1'b1, sdaMeta: 1'b1, sdaS: 1'b1, default: '0};
    end else begin
      h_q <= h_d;
    end
  end

  // Open-drain pins pull low only
  assign link.sclOut = 1'b0;
  assign link.sclOe = !h_q.sclHigh;
  assign link.sdaOutHost = 1'b0;
  assign link.sdaOeHost = h_q.sdaLow;
  assign cmdReady = h_q.state == H_IDLE;
  assign rdValid = h_q.rdValid;
  assign rdData = h_q.rdData;
  assign done = h_q.done;
  assign nacked = h_q.nacked;
endmodule
`default_nettype wire

// ---- eeprom_link_checker.sv ----
// Concurrent checks on the two-wire link between host and client
`timescale 1ns/100ps
`default_nettype none
module eeprom_link_checker #(
  parameter int WriteCycles = 3000
) (
  // Clocks and reset
  input wire logic clk,
  input wire logic linkClk,
  input wire logic rstn,
  // Link signals
  input wire logic sclOut,
  input wire logic sclOe,
  input wire logic sdaOutHost,
  input wire logic sdaOeHost,
  input wire logic sdaOutDev,
  input wire logic sdaOeDev,
  input wire logic scl,
  input wire logic sda,
  // Client status
  input wire logic writeBusy
);
  import eeprom_pkg::*;
  // Client pulls data low
  logic devLow;
  // Busy length in clk cycles
  int busyCnt_q;
  // Length of one client pull in link cycles
  int lowCnt_q;
  // Host clock low length in clk cycles
  int sclLowCnt_q;
  // Longest legal clock low: Start tail plus two byte quarters, with margin
  localparam int SclLowMax = 4 * QUARTER_CYC;
  assign devLow = sdaOeDev && !sdaOutDev;
  // Busy length counter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busyCnt_q <= 0;
    end else begin
      busyCnt_q <= writeBusy ? busyCnt_q + 1 : 0;
    end
  end
  // Pull length counter; a stuck pull would lock the bus
  always_ff @(posedge linkClk or negedge rstn) begin
    if (!rstn) begin
      lowCnt_q <= 0;
    end else begin
      lowCnt_q <= devLow ? lowCnt_q + 1 : 0;
    end
  end
  // Clock low counter; poll retries rely on the host clocking on
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclLowCnt_q <= 0;
    end else begin
      sclLowCnt_q <= (sclOe && !sclOut) ? sclLowCnt_q + 1 : 0;
    end
  end
  startQuiet_a: assert property (@(posedge linkClk) disable iff (!rstn)
    $fell(sda) && scl |-> !devLow [*8]) else $error("client pulls data right after Start");
  stopQuiet_a: assert property (@(posedge linkClk) disable iff (!rstn)
    $rose(sda) && scl |-> !devLow [*8]) else $error("client pulls data right after Stop");
  sclLowChange_a: assert property (@(posedge linkClk) disable iff (!rstn)
    $changed(devLow) |-> !scl) else $error("client changes data while clock high");
  busyNoAck_a: assert property (@(posedge clk) disable iff (!rstn)
    writeBusy && $past(writeBusy) |-> !devLow) else $error("client answers while busy");
  busyAtStop_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(writeBusy) |-> (scl && sda) [*8]) else $error("busy rose away from a Stop");
  busyLength_a: assert property (@(posedge clk) disable iff (!rstn)
    $fell(writeBusy) |-> busyCnt_q >= WriteCycles && busyCnt_q <= WriteCycles + 2)
    else $error("write cycle length wrong");
  pullBounded_a: assert property (@(posedge linkClk) disable iff (!rstn)
    lowCnt_q < 1600) else $error("client holds data low too long");
  sclLowBound_a: assert property (@(posedge clk) disable iff (!rstn)
    sclLowCnt_q < SclLowMax) else $error("host stalls the clock low");
  // Main scenarios
  busyEnd_c: cover property (@(posedge clk) disable iff (!rstn) $fell(writeBusy));
  busyPoll_c: cover property (@(posedge linkClk) disable iff (!rstn) $fell(sda) && scl && writeBusy);
  devPull_c: cover property (@(posedge linkClk) disable iff (!rstn) $rose(devLow));
  hostPull_c: cover property (@(posedge clk) disable iff (!rstn) $rose(sdaOeHost && !sdaOutHost));
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench: host and client joined over the two-wire link
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import eeprom_pkg::*;
  // Shortened write cycle
  localparam int WrCyc = 3000;
  // Client strap value
  localparam logic [2:0] SelPins = 3'h5;
  // Strap level on the client select pins, changed late in the run
  logic [2:0] devSel = SelPins;
  logic clk = 1'b0;
  logic linkClk = 1'b0;
  logic rstn = 1'b0;
  logic cmdValid = 1'b0;
  logic cmdReady;
  op_t cmdOp = OP_POLL;
  logic [2:0] cmdSelect = SelPins;
  logic [15:0] cmdAddr = 16'h0000;
  logic [7:0] cmdData = 8'h00;
  logic [7:0] cmdCount = 8'h00;
  logic rdValid;
  logic [7:0] rdData;
  logic done;
  logic nacked;
  logic writeBusy;
  int nErrors = 0;
  int samplesChecked = 0;
  int nStarts = 0;
  // Bytes read by the last command
  logic [7:0] rdQ[$];
  // Writes around the top of the array
  logic [15:0] wrAddr[3] = '{16'hfffe, 16'hffff, 16'h0000};
  logic [7:0] wrData[3] = '{8'h5a, 8'ha5, 8'h3c};
  eeprom_link_if lnk();
  // System clock
  always #5 clk = ~clk;
  // Link clock, offset so its edges never coincide with clk edges
  initial begin
    #0.3;
    forever #7.5 linkClk = ~linkClk;
  end
  eeprom_client #(.WriteCycles(WrCyc)) i_eeprom_client (.clk(clk), .rstn(rstn), .linkClk(linkClk),
    .link(lnk), .deviceSelectPins(devSel), .writeBusy(writeBusy));
  eeprom_host i_eeprom_host (.clk(clk), .rstn(rstn), .link(lnk), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdOp(cmdOp), .cmdSelect(cmdSelect), .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdCount(cmdCount),
    .rdValid(rdValid), .rdData(rdData), .done(done), .nacked(nacked));
  eeprom_link_checker #(.WriteCycles(WrCyc)) i_eeprom_link_checker (.clk(clk), .linkClk(linkClk),
    .rstn(rstn), .sclOut(lnk.sclOut), .sclOe(lnk.sclOe), .sdaOutHost(lnk.sdaOutHost),
    .sdaOeHost(lnk.sdaOeHost), .sdaOutDev(lnk.sdaOutDev), .sdaOeDev(lnk.sdaOeDev), .scl(lnk.scl),
    .sda(lnk.sda), .writeBusy(writeBusy));
  // Count Starts on the wire
  always @(negedge lnk.sda) begin
    if (lnk.scl === 1'b1) begin
      nStarts++;
    end
  end
  // Byte compare
  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nErrors++;
      $display("[ERR] t=%0t byte %h, expected %h", $time, got, exp);
    end
  endtask
  // Flag compare
  task automatic chkBit(input logic got, input logic exp);
    samplesChecked++;
    if (got !== exp) begin
      nErrors++;
      $display("[ERR] t=%0t flag %b, expected %b", $time, got, exp);
    end
  endtask
  // Verdict and end of run
  task automatic results();
    $display("Compares %0d, mismatches %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // One host command; waits for done under a bound, collects read bytes
  task automatic runCmd(input op_t op, input logic [15:0] addr, input logic [7:0] data,
      input logic [7:0] cnt, input logic [2:0] sel);
    int i;
    @(posedge clk);
    cmdOp <= op;
    cmdAddr <= addr;
    cmdData <= data;
    cmdCount <= cnt;
    cmdSelect <= sel;
    cmdValid <= 1'b1;
    @(posedge clk);
    cmdValid <= 1'b0;
    rdQ.delete();
    for (i = 0; i < 16000; i++) begin
      @(posedge clk);
      #1;
      if (rdValid === 1'b1) begin
        rdQ.push_back(rdData);
      end
      if (done === 1'b1) begin
        break;
      end
    end
    if (i == 16000) begin
      nErrors++;
      $display("[ERR] t=%0t command never finished", $time);
      results();
    end
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (10) @(posedge clk);
    // Each write is followed by polling until acknowledged
    for (int k = 0; k < 3; k++) begin
      runCmd(OP_WRITE, wrAddr[k], wrData[k], 8'h00, SelPins);
      chkBit(writeBusy, 1'b1);
      chkBit(nacked, 1'b0);
      nStarts = 0;
      runCmd(OP_POLL, 16'h0000, 8'h00, 8'h00, SelPins);
      chkBit(nStarts > 1, 1'b1);
      chkBit(nacked, 1'b0);
      chkBit(writeBusy, 1'b0);
      chkBit(cmdReady, 1'b1);
    end
    // One-byte random read sets the pointer
    runCmd(OP_RAND_READ, 16'hfffe, 8'h00, 8'h01, SelPins);
    chkByte(8'(rdQ.size()), 8'h01);
    chkByte(rdQ[0], 8'h5a);
    // Current read acknowledged across the top of the array
    runCmd(OP_CUR_READ, 16'h0000, 8'h00, 8'h02, SelPins);
    chkByte(8'(rdQ.size()), 8'h02);
    chkByte(rdQ[0], 8'ha5);
    chkByte(rdQ[1], 8'h3c);
    // Select bits that do not match the strap
    runCmd(OP_CUR_READ, 16'h0000, 8'h00, 8'h01, 3'h2);
    chkBit(nacked, 1'b1);
    chkByte(8'(rdQ.size()), 8'h00);
    // Same select bits answered once the strap follows them
    devSel <= 3'h2;
    runCmd(OP_RAND_READ, 16'h0000, 8'h00, 8'h01, 3'h2);
    chkBit(nacked, 1'b0);
    chkByte(rdQ[0], 8'h3c);
    results();
  end
endmodule
`default_nettype wire
